// ===== design/acs_calib_seq.v
// Calibration sequencer of a serial successive-approximation converter
`default_nettype none
`include "acs_consts.vh"

module acs_calib_seq #(
  parameter CYC_FULL   = `ACS_CYC_FULL,
  parameter CYC_GO     = `ACS_CYC_GO,
  parameter CYC_SINGLE = `ACS_CYC_SINGLE,
  parameter CYC_PWRUP  = `ACS_CYC_PWRUP,
  parameter TW         = 24,
  parameter EW         = 8
) (
  input  wire                  clk,
  input  wire                  rst,
  input  wire                  calibrate_n,
  input  wire                  convert_start_n,
  input  wire                  soft_calibrate_start_bit,
  input  wire                  ctrl_write_done,
  input  wire [`ACS_SEL_W-1:0] cal_select,
  input  wire                  bipolar,
  input  wire                  powered_down,
  input  wire signed [EW-1:0]  measured_error,
  input  wire [EW-1:0]         ofs_limit,
  input  wire [EW-1:0]         gain_limit,
  output wire                  busy,
  output reg  [2:0]            trim_step,
  output reg                   trim_midscale,
  output reg                   internal_reset,
  output reg                   ofs_trim_we,
  output reg                   gain_trim_we,
  output reg                   dac_trim_we,
  output reg  signed [EW-1:0]  trim_value,
  output reg                   wait_convert
);

  // One-hot sequencer states
  localparam S_IDLE  = 6'b000001;
  localparam S_RESET = 6'b000010;
  localparam S_DAC   = 6'b000100;
  localparam S_GAIN  = 6'b001000;
  localparam S_OFS   = 6'b010000;
  localparam S_WAIT  = 6'b100000;

  // Step lengths; a full run spends its whole time over DAC, gain and offset,
  // so the DAC step leaves room for the two single steps that follow it
  localparam integer LEN_DAC_I = CYC_FULL - 2 * CYC_SINGLE;
  localparam integer LEN_GO_I  = CYC_GO - CYC_SINGLE;
  localparam integer LEN_ONE_I = CYC_SINGLE;

  reg [5:0]            state;
  reg [5:0]            next_state;
  reg [`ACS_SEL_W-1:0] sel;
  reg                  cal_n_q;
  reg                  conv_n_q;
  reg                  pwr_up_pending;
  reg                  pwr_up_done;
  reg [TW-1:0]         pwr_count;
  reg                  load;
  reg [TW-1:0]         length;
  wire                 step_run;
  wire                 step_done;

  wire cal_rise  = calibrate_n & ~cal_n_q;
  wire cal_fall  = ~calibrate_n & cal_n_q;
  wire conv_rise = convert_start_n & ~conv_n_q;
  wire sw_start  = ctrl_write_done & soft_calibrate_start_bit;
  wire start     = cal_rise | sw_start;
  wire is_sys    = sel[`ACS_SEL_SYS_BIT];
  wire [1:0] typ = sel[1:0];

  // Clamp an error to the symmetric trim range
  function signed [EW-1:0] clamp;
    input signed [EW-1:0] err;
    input        [EW-1:0] lim;
    reg   signed [EW-1:0] slim;
    begin
      slim = $signed(lim);
      if (err > slim)
        clamp = slim;
      else if (err < -slim)
        clamp = -slim;
      else
        clamp = err;
    end
  endfunction

  // Step length from type and phase; gain+offset phases share one length
  function [TW-1:0] step_len;
    input [1:0] t;
    input       dac;
    begin
      if (dac)
        step_len = LEN_DAC_I[TW-1:0];
      else if (t == `ACS_TYPE_GAIN_OFS)
        step_len = LEN_GO_I[TW-1:0];
      else
        step_len = LEN_ONE_I[TW-1:0];
    end
  endfunction

  // Pin edge detectors
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cal_n_q  <= 1'b1;
      conv_n_q <= 1'b1;
    end else begin
      cal_n_q  <= calibrate_n;
      conv_n_q <= convert_start_n;
    end
  end

  // Power-up recovery timer, started at the pin's falling edge when powered down
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pwr_count      <= {TW{1'b0}};
      pwr_up_pending <= 1'b0;
      pwr_up_done    <= 1'b1;
    end else if (cal_fall) begin
      pwr_up_pending <= powered_down;
      pwr_up_done    <= ~powered_down;
      pwr_count      <= CYC_PWRUP[TW-1:0];
    end else if (pwr_up_pending) begin
      if (pwr_count <= {{(TW-1){1'b0}}, 1'b1}) begin
        pwr_up_pending <= 1'b0;
        pwr_up_done    <= 1'b1;
      end else begin
        pwr_count <= pwr_count - {{(TW-1){1'b0}}, 1'b1};
      end
    end
  end

  // Internal reset follows the low calibrate pin
  always @(posedge clk or posedge rst) begin
    if (rst)
      internal_reset <= 1'b0;
    else
      internal_reset <= ~calibrate_n;
  end

  acs_step_timer #(.W(TW)) u_timer (
    .clk     (clk),
    .rst     (rst),
    .load    (load),
    .length  (length),
    .running (step_run),
    .done    (step_done)
  );

  // Next state and timer load
  always @* begin
    next_state = state;
    load       = 1'b0;
    length     = {TW{1'b0}};
    case (state)
      S_IDLE, S_RESET, S_WAIT: begin
        if (!calibrate_n) begin
          next_state = S_RESET;
        end else if (state == S_WAIT && conv_rise) begin
          next_state = S_OFS;
          load       = 1'b1;
          length     = step_len(`ACS_TYPE_OFFSET, 1'b0);
        end else if (start) begin
          load = 1'b1;
          case (cal_select[1:0])
            `ACS_TYPE_FULL: begin
              next_state = S_DAC;
              length     = step_len(`ACS_TYPE_FULL, 1'b1);
            end
            `ACS_TYPE_GAIN_OFS: begin
              next_state = S_GAIN;
              length     = step_len(`ACS_TYPE_GAIN_OFS, 1'b0);
            end
            `ACS_TYPE_OFFSET: begin
              next_state = S_OFS;
              length     = step_len(`ACS_TYPE_OFFSET, 1'b0);
            end
            default: begin
              next_state = S_GAIN;
              length     = step_len(`ACS_TYPE_GAIN, 1'b0);
            end
          endcase
        end else if (state == S_RESET) begin
          next_state = S_IDLE;
        end
      end
      S_DAC: begin
        if (step_done) begin
          next_state = S_GAIN;
          load       = 1'b1;
          length     = step_len(`ACS_TYPE_GAIN, 1'b0);
        end
      end
      S_GAIN: begin
        if (step_done) begin
          if (typ == `ACS_TYPE_GAIN) begin
            next_state = S_IDLE;
          end else if (is_sys) begin
            next_state = S_WAIT;
          end else begin
            next_state = S_OFS;
            load       = 1'b1;
            length     = (typ == `ACS_TYPE_GAIN_OFS) ? step_len(`ACS_TYPE_GAIN_OFS, 1'b0)
                                                     : step_len(`ACS_TYPE_OFFSET, 1'b0);
          end
        end
      end
      S_OFS: begin
        if (step_done)
          next_state = S_IDLE;
      end
      default: next_state = S_IDLE;
    endcase
  end

  // State and latched selection; a start samples the field
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= S_IDLE;
      sel   <= {`ACS_SEL_W{1'b0}};
    end else begin
      state <= next_state;
      // A new start from the wait gap must also take the field
      if (load && !busy && !(state == S_WAIT && conv_rise))
        sel <= cal_select;
    end
  end

  // Busy in the DAC, gain and offset states; low in wait gap
  assign busy = (state == S_DAC) | (state == S_GAIN) | (state == S_OFS);

  // Step code and wait flag every cycle; trim writes and values at each step end
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      trim_step     <= `ACS_STEP_NONE;
      trim_midscale <= 1'b0;
      ofs_trim_we   <= 1'b0;
      gain_trim_we  <= 1'b0;
      dac_trim_we   <= 1'b0;
      trim_value    <= {EW{1'b0}};
      wait_convert  <= 1'b0;
    end else begin
      ofs_trim_we  <= 1'b0;
      gain_trim_we <= 1'b0;
      dac_trim_we  <= 1'b0;
      wait_convert <= (next_state == S_WAIT);
      case (next_state)
        S_DAC:   trim_step <= `ACS_STEP_DAC;
        S_GAIN:  trim_step <= `ACS_STEP_GAIN;
        S_OFS:   trim_step <= `ACS_STEP_OFFSET;
        default: trim_step <= (pwr_up_done ? `ACS_STEP_NONE : `ACS_STEP_POWERUP);
      endcase
      if (step_done) begin
        case (state)
          S_DAC: begin
            dac_trim_we <= 1'b1;
            trim_value  <= measured_error;
          end
          S_GAIN: begin
            gain_trim_we <= 1'b1; // positive full scale
            trim_value   <= is_sys ? clamp(measured_error, gain_limit) : measured_error;
          end
          S_OFS: begin
            ofs_trim_we   <= 1'b1;
            trim_midscale <= bipolar;
            trim_value    <= is_sys ? clamp(measured_error, ofs_limit) : measured_error;
          end
          default: trim_value <= trim_value;
        endcase
      end
    end
  end

endmodule // acs_calib_seq
`default_nettype wire

// ===== design/acs_consts.vh
// Constants for the calibration sequencer: select codes, step codes and durations
`ifndef ACS_CONSTS_VH
`define ACS_CONSTS_VH

// Calibration select field (bit 2 = system, bits 1:0 = type)
`define ACS_SEL_W          3
`define ACS_SEL_SYS_BIT    2
`define ACS_TYPE_FULL      2'h0
`define ACS_TYPE_GAIN_OFS  2'h1
`define ACS_TYPE_OFFSET    2'h2
`define ACS_TYPE_GAIN      2'h3

// Trim step codes reported on trim_step
`define ACS_STEP_NONE      3'h0
`define ACS_STEP_DAC       3'h1
`define ACS_STEP_GAIN      3'h2
`define ACS_STEP_OFFSET    3'h3
`define ACS_STEP_POWERUP   3'h4

// Durations in nanoseconds at the reference master clock
`define ACS_T_FULL_NS      41700000
`define ACS_T_GO_NS        9260000
`define ACS_T_SINGLE_NS    4630000
`define ACS_T_PWRUP_NS     5000
`define ACS_CLK_NS         20

// Cycle counts derived from the times (rounded down, power-up rounded up, longest times)
`define ACS_CYC_FULL       (`ACS_T_FULL_NS / `ACS_CLK_NS)
`define ACS_CYC_GO         (`ACS_T_GO_NS / `ACS_CLK_NS)
`define ACS_CYC_SINGLE     (`ACS_T_SINGLE_NS / `ACS_CLK_NS)
`define ACS_CYC_PWRUP      ((`ACS_T_PWRUP_NS + `ACS_CLK_NS - 1) / `ACS_CLK_NS)

// Trim range limits in parts per thousand of the reference
`define ACS_OFS_LIMIT_PPT  50
`define ACS_GAIN_LIMIT_PPT 25

`endif

// ===== design/acs_step_timer.v
// Down counter timing one calibration step
`default_nettype none

module acs_step_timer #(
  parameter W = 24
) (
  input  wire         clk,
  input  wire         rst,
  input  wire         load,
  input  wire [W-1:0] length,
  output reg          running,
  output reg          done
);

  reg [W-1:0] count;

  // Load wins over an ongoing count so a restart is clean
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      count   <= {W{1'b0}};
      running <= 1'b0;
      done    <= 1'b0;
    end else begin
      done <= 1'b0;
      if (load) begin
        count   <= length;
        running <= 1'b1;
      end else if (running) begin
        if (count <= {{(W-1){1'b0}}, 1'b1}) begin
          running <= 1'b0;
          done    <= 1'b1;
        end else begin
          count <= count - {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule // acs_step_timer
`default_nettype wire

// ===== dv/acs_calib_seq_monitor.sv
// Port checker for the calibration sequencer
`default_nettype none
module acs_mon #(parameter int CYC_FULL = 40) (
  input wire logic clk,
  input wire logic rst,
  input wire logic calibrate_n,
  input wire logic convert_start_n,
  input wire logic soft_calibrate_start_bit,
  input wire logic ctrl_write_done,
  input wire logic bipolar,
  input wire logic powered_down,
  input wire logic busy,
  input wire logic internal_reset,
  input wire logic ofs_trim_we,
  input wire logic trim_midscale,
  input wire logic wait_convert
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  int unsigned run;
  // Length of the current busy stretch
  always @(posedge clk or posedge rst)
    if (rst) run <= 0;
    else run <= busy ? run + 1 : 0;
  a_pin_starts_busy: assert property ($rose(calibrate_n) && !busy && !powered_down |=> busy)
    else $error("busy missed pin start");
  a_soft_starts_busy: assert property (
    ctrl_write_done && soft_calibrate_start_bit && !busy && !powered_down |=> busy)
    else $error("busy missed soft start");
  a_reset_while_low: assert property (!calibrate_n |=> internal_reset)
    else $error("no internal reset");
  a_reset_released: assert property (calibrate_n |=> !internal_reset)
    else $error("internal reset stuck");
  a_busy_bounded: assert property (run <= CYC_FULL + 4)
    else $error("busy too long");
  a_busy_holds: assert property ($rose(busy) |-> busy[*8])
    else $error("busy dropped early");
  a_convert_resumes: assert property (wait_convert && $rose(convert_start_n) |=> busy)
    else $error("offset phase not started");
  a_convert_ignored: assert property (
    !wait_convert && !busy && $rose(convert_start_n) && $stable(calibrate_n)
    && !ctrl_write_done |=> !busy) else $error("stray start");
  a_wait_not_busy: assert property (wait_convert |-> !busy)
    else $error("busy while waiting");
  a_mid_follows_mode: assert property (
    ofs_trim_we && $stable(bipolar) |=> trim_midscale == bipolar)
    else $error("offset point wrong");
  c_wait: cover property ($rose(wait_convert));
  c_soft: cover property (ctrl_write_done && soft_calibrate_start_bit);
  c_done: cover property ($fell(busy));
endmodule // acs_mon
bind acs_calib_seq acs_mon #(.CYC_FULL(CYC_FULL)) acs_mon_i (.clk(clk), .rst(rst),
  .calibrate_n(calibrate_n), .convert_start_n(convert_start_n),
  .soft_calibrate_start_bit(soft_calibrate_start_bit), .ctrl_write_done(ctrl_write_done),
  .bipolar(bipolar), .powered_down(powered_down), .busy(busy),
  .internal_reset(internal_reset), .ofs_trim_we(ofs_trim_we),
  .trim_midscale(trim_midscale), .wait_convert(wait_convert));
`default_nettype wire

// ===== dv/acs_calib_seq_tb.sv
// Testbench for the calibration sequencer
`default_nettype none
module acs_calib_seq_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CF = 40, CG = 20, CS = 10;
  logic clk = 1'b0, rst = 1'b1, bip = 1'b0, pdn = 1'b0;
  logic [2:0] sel = 3'h0;
  logic [7:0] err = 8'h00, cap;
  wire logic cal_n, conv_n, sbit, wdone, busy, mid, irst, owe, gwe, dwe, wconv;
  wire logic [2:0] step;
  wire logic [7:0] tval;
  int failures = 0, total_checks = 0, n;
  int len[4];
  always #10 clk = ~clk;
  acs_host acs_host_i (.clk(clk), .cal_n(cal_n), .conv_n(conv_n), .sbit(sbit), .wdone(wdone));
  acs_calib_seq #(.CYC_FULL(CF), .CYC_GO(CG), .CYC_SINGLE(CS), .CYC_PWRUP(3)) acs_calib_seq_i (
    .clk(clk), .rst(rst), .calibrate_n(cal_n), .convert_start_n(conv_n),
    .soft_calibrate_start_bit(sbit), .ctrl_write_done(wdone), .cal_select(sel),
    .bipolar(bip), .powered_down(pdn), .measured_error(err), .ofs_limit(8'h32),
    .gain_limit(8'h19), .busy(busy), .trim_step(step), .trim_midscale(mid),
    .internal_reset(irst), .ofs_trim_we(owe), .gain_trim_we(gwe), .dac_trim_we(dwe),
    .trim_value(tval), .wait_convert(wconv));
  task automatic print_verdict();
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_in(input int v, lo, hi);
    total_checks++;
    if (v < lo || v > hi) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, v, lo);
    end
  endtask
  // Bounded wait for busy level; grabs any gain or offset trim value written
  task automatic wait_busy(input logic lvl);
    n = 0;
    while (busy !== lvl && n < 200) begin
      if (owe === 1'b1 || gwe === 1'b1) cap = tval;
      @(negedge clk);
      n++;
    end
    // A strobe at the busy fall edge is still seen here
    if (owe === 1'b1 || gwe === 1'b1) cap = tval;
    if (n == 200) begin
      failures++;
      print_verdict();
    end
  endtask
  task automatic pin_run(input logic [2:0] s);
    sel = s;
    acs_host_i.pin_pulse(4);
    @(negedge clk);
    chk(busy, 1'b1);
    chk(step, (s[1:0] == 2'h0) ? 8'h01 : (s[1:0] == 2'h2) ? 8'h03 : 8'h02);
    wait_busy(1'b0);
  endtask
  // Power-up recovery shows while the pin is low, then clears
  task automatic pwr_recover();
    sel = 3'h2;
    pdn = 1'b1;
    acs_host_i.pin_pulse(3);
    chk(step, 8'h04);
    @(negedge clk);
    wait_busy(1'b0);
    acs_host_i.pin_pulse(6);
    chk(step, 8'h00);
    @(negedge clk);
    wait_busy(1'b0);
    pdn = 1'b0;
  endtask
  // All four self types; full longest
  task automatic self_types();
    for (int t = 0; t < 4; t++) begin
      pin_run({1'b0, t[1:0]});
      len[t] = n + 1;
    end
    chk_in(len[0], CF, CF + 4);
    chk_in(len[1], CG - 2, CG + 4);
    chk_in(len[2], CS, CS + 2);
    chk_in(len[3], CS, CS + 2);
  endtask
  // Software start, offset point per input mode
  task automatic soft_offset();
    sel = 3'h6;
    acs_host_i.soft_write(1'b0);
    chk(busy, 1'b0);
    for (int b = 1; b >= 0; b--) begin
      bip = b[0];
      acs_host_i.soft_write(1'b1);
      chk(busy, 1'b1);
      wait_busy(1'b0);
      chk(mid, b[0]);
    end
  endtask
  // Two-phase system sequences
  task automatic sys_two();
    for (int t = 0; t < 4; t++) begin
      acs_host_i.conv_pulse();
      @(negedge clk);
      chk(busy, 1'b0);
      pin_run({2'h2, t != 0});
      chk(wconv, 1'b1);
      acs_host_i.conv_pulse();
      @(negedge clk);
      chk(busy, 1'b1);
      wait_busy(1'b0);
      chk_in(n + 1, CS, CS + 2);
      chk(wconv, 1'b0);
    end
  endtask
  // Errors beyond range clamp at the trim limit
  task automatic sys_clamp();
    err = 8'h64;
    for (int r = 0; r < 2; r++) begin
      pin_run(3'h6);
      chk(tval, 8'h32);
      pin_run(3'h7);
      chk(cap, 8'h19);
    end
  endtask
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    self_types();
    soft_offset();
    sys_two();
    sys_clamp();
    pwr_recover();
    print_verdict();
  end
endmodule // acs_calib_seq_tb
`default_nettype wire

// ===== dv/acs_host.sv
// Host model driving the calibrate and convert strobes
`default_nettype none
module acs_host (
  input  wire logic clk,
  output var  logic cal_n,
  output var  logic conv_n,
  output var  logic sbit,
  output var  logic wdone
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle levels
  initial begin
    cal_n = 1'b1;
    conv_n = 1'b1;
    sbit = 1'b0;
    wdone = 1'b0;
  end
  // Low pulse, w cycles wide
  task automatic pin_pulse(input int w);
    @(negedge clk);
    cal_n = 1'b0;
    repeat (w) @(negedge clk);
    cal_n = 1'b1;
  endtask
  // One-cycle control write carrying the start bit
  task automatic soft_write(input logic b);
    @(negedge clk);
    sbit = b;
    wdone = 1'b1;
    @(negedge clk);
    wdone = 1'b0;
    sbit = ~b; // Meaningless without the strobe
  endtask
  // Low pulse on the convert pin, two cycles wide
  task automatic conv_pulse();
    @(negedge clk);
    conv_n = 1'b0;
    repeat (2) @(negedge clk);
    conv_n = 1'b1;
  endtask
endmodule // acs_host
`default_nettype wire
